// ---- smi_pkg.sv ----
package smi_pkg;
  // Register offsets (offsets 05h/06h are not multiples of four: index*4)
  localparam logic [7:0] SMI_IDX_CFG = 8'h05;
  localparam logic [7:0] SMI_IDX_MAPEN = 8'h06;
  localparam logic [7:0] SMI_IDX_STATUS = 8'h04;
  localparam logic [7:0] SMI_IDX_CTRL = 8'h03;
  localparam logic [7:0] SMI_IDX_EVT_STAT = 8'h10;
  localparam logic [7:0] SMI_IDX_EVT_CLR = 8'h11;
  localparam logic [7:0] SMI_IDX_EVT_EN = 8'h12;
  localparam logic [7:0] SMI_IDX_PINS = 8'h13;
  // Reset values
  localparam logic [7:0] SMI_CFG_RST = 8'h00;
  localparam logic [7:0] SMI_MAPEN_RST = 8'h00;
  localparam logic [7:0] SMI_CTRL_RST = 8'h00;
  localparam logic [3:0] SMI_EVT_EN_RST = 4'h0;
  // Field positions
  localparam int SMI_CFG_EN_LSB = 0;
  localparam int SMI_CFG_ROUTE_LSB = 4;
  localparam int SMI_MAP_MEM_LSB = 0;
  localparam int SMI_MAP_IO0_BIT = 6;
  localparam int SMI_MAP_IO1_BIT = 7;
  localparam int SMI_CTRL_REDIR_BIT = 4;
  localparam int SMI_CTRL_IOCARD_BIT = 5;
  localparam int SMI_ST_BATDEAD = 0;
  localparam int SMI_ST_BATWARN = 1;
  localparam int SMI_ST_READY = 2;
  localparam int SMI_ST_DETECT = 3;
  // Routing codes
  localparam logic [3:0] SMI_ROUTE_OFF = 4'h0;
  localparam logic [3:0] SMI_RSV_A = 4'h1;
  localparam logic [3:0] SMI_RSV_B = 4'h2;
  localparam logic [3:0] SMI_RSV_C = 4'h6;
  localparam logic [3:0] SMI_RSV_D = 4'h8;
  localparam logic [3:0] SMI_RSV_E = 4'hd;
  localparam logic [3:0] SMI_ROUTE_DACK = 4'h9;
  localparam logic [3:0] SMI_ROUTE_DRQ = 4'ha;
  localparam logic [3:0] SMI_ROUTE_LED = 4'hc;
  localparam logic [3:0] SMI_ROUTE_RING = 4'hf;
  // AHB-Lite codes
  localparam logic [1:0] SMI_HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] SMI_HSIZE_WORD = 3'b010;
endpackage

// ---- smi_sync_edge.sv ----
`timescale 1ns/100ps
`default_nettype none
module smi_sync_edge (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw pin and results
  input wire logic pinAsync,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  // Two-stage synchroniser and edge history, tracking the pin through reset
  always_ff @(posedge clk) begin
    meta_r <= pinAsync;
    sync_r <= meta_r;
    last_r <= sync_r;
  end

  // Edges masked in reset, so release shows no false edge
  assign level = sync_r;
  assign rise = sync_r & ~last_r & ~rst;
  assign fall = ~sync_r & last_r & ~rst;
endmodule
`default_nettype wire

// ---- smi_socket_regs.sv ----
// Behaviour
// - Config register at 05h: four source enables and routing field, reset zero.
// - Enable bit 0 with battery-dead/status-change flag raises management interrupt.
// - Enable bit 1 with battery-warning flag interrupts; ignored in I/O card mode.
// - Enable bit 2 with ready-change flag raises management interrupt.
// - Enable bit 3 with card-detect-change flag raises management interrupt.
// - Bits 7:4 pick IRQ pin n; 0000 and reserved codes drive none.
// - IRQ 9, 10, 12, 15 pins may carry DACK, DRQ, LED, ring functions.
// - Mapping enable 06h bits 0-4 gate memory windows 0 to 4.
// - Mapping enable bit 5 has no effect; full address decodes chip-select.
// - Mapping enable bit 6 gates responses to I/O window 0.
// - Mapping enable bit 7 gates responses to I/O window 1.
// - Reading the status change register clears every change flag.
// - Battery-dead flag sets on falling edge; either edge in I/O mode.
// - Redirect bit sends management interrupt to processor line instead.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module smi_socket_regs
  import smi_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Card pins
  input wire logic batteryDeadStatusPin,
  input wire logic batteryWarningPin,
  input wire logic cardReadyIrqPin,
  input wire logic cardDetectPinA,
  input wire logic cardDetectPinB,
  // Window hits from the decoders
  input wire logic [4:0] memWindowHit,
  input wire logic [1:0] ioWindowHit,
  // Window responses
  output logic [4:0] memWindowRespond,
  output logic [1:0] ioWindowRespond,
  // Interrupt outputs
  output logic [15:0] hostIrq,
  output logic processorInterruptLine,
  output logic [3:0] altShareSel,
  output logic eventIrq
);
  ////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] cfg_r;
  logic [7:0] mapEn_r;
  logic [7:0] ctrl_r;
  logic [3:0] chg_r;
  logic [3:0] chg_nxt;
  logic [3:0] evtStat_r;
  logic [3:0] evtEn_r;
  logic [4:0] pinLevel;
  logic [4:0] pinRise;
  logic [4:0] pinFall;
  logic [4:0] pinIn;
  logic phaseValid_r;
  logic phaseWrite_r;
  logic [7:0] phaseIdx_r;
  logic [3:0] srcEvt;
  logic mgmtIrq;
  logic [3:0] route;
  logic routeLegal;
  logic ioCard;
  logic statusRead;
  logic [31:0] rdData;
  logic [3:0] evtClr;

  function automatic logic isReserved(input logic [3:0] code);
    isReserved = (code == SMI_ROUTE_OFF) || (code == SMI_RSV_A) || (code == SMI_RSV_B)
      || (code == SMI_RSV_C) || (code == SMI_RSV_D) || (code == SMI_RSV_E);
  endfunction

  function automatic logic [7:0] wordIdx(input logic [31:0] addr);
    wordIdx = addr[9:2];
  endfunction

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  assign pinIn = {cardDetectPinB, cardDetectPinA, cardReadyIrqPin, batteryWarningPin,
    batteryDeadStatusPin};

  for (genvar i = 0; i < 5; i++) begin : gSync
    smi_sync_edge uSync (
      .clk(clk),
      .rst(rst),
      .pinAsync(pinIn[i]),
      .level(pinLevel[i]),
      .rise(pinRise[i]),
      .fall(pinFall[i])
    );
  end

  ////////////////////////////////////////////////////////////////
  // AHB-Lite address phase capture
  always_ff @(posedge clk) begin
    if (rst) begin
      phaseValid_r <= 1'b0;
      phaseWrite_r <= 1'b0;
      phaseIdx_r <= 8'h00;
    end else if (hready) begin
      phaseValid_r <= hsel && (htrans == SMI_HTRANS_NONSEQ || htrans == 2'b11);
      phaseWrite_r <= hwrite;
      phaseIdx_r <= wordIdx(haddr);
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign statusRead = phaseValid_r && !phaseWrite_r && (phaseIdx_r == SMI_IDX_STATUS);
  assign evtClr = (phaseValid_r && phaseWrite_r && phaseIdx_r == SMI_IDX_EVT_CLR)
    ? hwdata[3:0] : 4'h0;

  ////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= SMI_CFG_RST;
      mapEn_r <= SMI_MAPEN_RST;
      ctrl_r <= SMI_CTRL_RST;
      evtEn_r <= SMI_EVT_EN_RST;
    end else if (phaseValid_r && phaseWrite_r) begin
      unique case (phaseIdx_r)
        SMI_IDX_CFG: cfg_r <= hwdata[7:0];
        SMI_IDX_MAPEN: mapEn_r <= hwdata[7:0];
        SMI_IDX_CTRL: ctrl_r <= hwdata[7:0];
        SMI_IDX_EVT_EN: evtEn_r <= hwdata[3:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Status change flags
  assign ioCard = ctrl_r[SMI_CTRL_IOCARD_BIT];
  assign srcEvt[SMI_ST_BATDEAD] = ioCard ? (pinRise[0] | pinFall[0]) : pinFall[0];
  assign srcEvt[SMI_ST_BATWARN] = !ioCard && pinFall[1];
  assign srcEvt[SMI_ST_READY] = !ioCard && (pinRise[2] | pinFall[2]);
  assign srcEvt[SMI_ST_DETECT] = pinRise[3] | pinFall[3] | pinRise[4] | pinFall[4];

  // Set beats the read clear
  always_comb begin
    chg_nxt = statusRead ? 4'h0 : chg_r;
    chg_nxt = chg_nxt | srcEvt;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chg_r <= 4'h0;
    end else begin
      chg_r <= chg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Management interrupt
  always_comb begin
    mgmtIrq = (cfg_r[SMI_CFG_EN_LSB + 0] & chg_r[SMI_ST_BATDEAD])
      | (cfg_r[SMI_CFG_EN_LSB + 1] & chg_r[SMI_ST_BATWARN] & !ioCard)
      | (cfg_r[SMI_CFG_EN_LSB + 2] & chg_r[SMI_ST_READY])
      | (cfg_r[SMI_CFG_EN_LSB + 3] & chg_r[SMI_ST_DETECT]);
  end
  // Level until the status read clears the flags

  assign route = cfg_r[SMI_CFG_ROUTE_LSB +: 4];
  assign routeLegal = !isReserved(route);

  always_ff @(posedge clk) begin
    if (rst) begin
      hostIrq <= 16'h0000;
      processorInterruptLine <= 1'b0;
      altShareSel <= 4'h0;
    end else begin
      processorInterruptLine <= mgmtIrq && ctrl_r[SMI_CTRL_REDIR_BIT];
      hostIrq <= (mgmtIrq && !ctrl_r[SMI_CTRL_REDIR_BIT] && routeLegal)
        ? (16'h0001 << route) : 16'h0000;
      // Flags pins whose alternate function loses to the interrupt
      altShareSel <= {route == SMI_ROUTE_RING, route == SMI_ROUTE_LED,
        route == SMI_ROUTE_DRQ, route == SMI_ROUTE_DACK};
    end
  end

  ////////////////////////////////////////////////////////////////
  // Window gating
  always_ff @(posedge clk) begin
    if (rst) begin
      memWindowRespond <= 5'h00;
      ioWindowRespond <= 2'h0;
    end else begin
      // Bit 5 is stored but steers nothing
      memWindowRespond <= memWindowHit & mapEn_r[SMI_MAP_MEM_LSB +: 5];
      ioWindowRespond[0] <= ioWindowHit[0] & mapEn_r[SMI_MAP_IO0_BIT];
      ioWindowRespond[1] <= ioWindowHit[1] & mapEn_r[SMI_MAP_IO1_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Event status for the interrupt output
  always_ff @(posedge clk) begin
    if (rst) begin
      evtStat_r <= 4'h0;
    end else begin
      evtStat_r <= (evtStat_r & ~evtClr) | srcEvt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      eventIrq <= 1'b0;
    end else begin
      eventIrq <= |(evtStat_r & evtEn_r);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read data
  always_comb begin
    rdData = 32'h0000_0000;
    unique case (phaseIdx_r)
      SMI_IDX_CFG: rdData[7:0] = cfg_r;
      SMI_IDX_MAPEN: rdData[7:0] = mapEn_r;
      SMI_IDX_CTRL: rdData[7:0] = ctrl_r;
      SMI_IDX_STATUS: rdData[3:0] = chg_r;
      SMI_IDX_EVT_STAT: rdData[3:0] = evtStat_r;
      SMI_IDX_EVT_EN: rdData[3:0] = evtEn_r;
      SMI_IDX_PINS: rdData[4:0] = pinLevel;
      default: rdData = 32'h0000_0000;
    endcase
  end

  assign hrdata = (phaseValid_r && !phaseWrite_r) ? rdData : 32'h0000_0000;
endmodule
`default_nettype wire

// ---- smi_socket_regs_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module smi_socket_regs_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [4:0] memWindowHit,
  input wire logic [1:0] ioWindowHit,
  input wire logic [4:0] memWindowRespond,
  input wire logic [1:0] ioWindowRespond,
  input wire logic [15:0] hostIrq,
  input wire logic processorInterruptLine,
  input wire logic [3:0] altShareSel,
  input wire logic eventIrq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_reset_quiet: assert property ($fell(rst) |-> hostIrq == 16'h0 && !eventIrq)
    else $error("interrupt after reset");
  a_mem_gate: assert property ((memWindowRespond & ~$past(memWindowHit)) == 5'h0)
    else $error("memory response without hit");
  a_io_gate: assert property ((ioWindowRespond & ~$past(ioWindowHit)) == 2'h0)
    else $error("io response without hit");
  a_irq_onehot: assert property ($onehot0(hostIrq))
    else $error("several irq pins driven");
  a_irq_reserved: assert property ((hostIrq & 16'h2147) == 16'h0)
    else $error("reserved irq pin driven");
  a_redir_only: assert property (processorInterruptLine |-> hostIrq == 16'h0)
    else $error("irq pin driven while redirected");
  a_alt_share: assert property ((hostIrq & 16'h9600) != 16'h0 |->
    altShareSel == {hostIrq[15], hostIrq[12], hostIrq[10], hostIrq[9]})
    else $error("shared pin select wrong");
endmodule
bind smi_socket_regs smi_socket_regs_chk smi_socket_regs_chk_inst (.clk(clk), .rst(rst),
  .hreadyout(hreadyout), .hresp(hresp), .memWindowHit(memWindowHit),
  .ioWindowHit(ioWindowHit), .memWindowRespond(memWindowRespond),
  .ioWindowRespond(ioWindowRespond), .hostIrq(hostIrq),
  .processorInterruptLine(processorInterruptLine), .altShareSel(altShareSel),
  .eventIrq(eventIrq));
`default_nettype wire

// ---- smi_host_bfm.sv ----
`timescale 1ns/100ps
`default_nettype none
module smi_host_bfm
  import smi_pkg::*;
(
  // Clock and bus
  input wire logic clk,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = SMI_HSIZE_WORD;
    hwdata = 32'h0;
  end
  // One word transfer
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= SMI_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  import smi_pkg::*;
  logic clk = 1'b0;
  logic rst, hsel, hwrite, hreadyout, hresp, procIrq, evtIrq;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  logic [1:0] htrans, ioHit, ioResp;
  logic [2:0] hsize;
  logic [4:0] pins, memHit, memResp;
  logic [15:0] hostIrq;
  logic [3:0] altSel;
  int n_mismatch, samples_checked;
  always #4 clk = ~clk;
  smi_host_bfm smi_host_bfm_inst (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
  smi_socket_regs smi_socket_regs_inst (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .batteryDeadStatusPin(pins[0]),
    .batteryWarningPin(pins[1]), .cardReadyIrqPin(pins[2]), .cardDetectPinA(pins[3]),
    .cardDetectPinB(pins[4]), .memWindowHit(memHit), .ioWindowHit(ioHit),
    .memWindowRespond(memResp), .ioWindowRespond(ioResp), .hostIrq(hostIrq),
    .processorInterruptLine(procIrq), .altShareSel(altSel), .eventIrq(evtIrq));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    smi_host_bfm_inst.xfer(1'b1, a, d, rdata);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    smi_host_bfm_inst.xfer(1'b0, a, 32'h0, rdata);
    chk(what, exp, rdata);
  endtask
  // Program, move one pin, check irq, read-clear status
  task automatic evt(input logic [7:0] ctl, input logic [7:0] cfg, input int p, input logic v,
                     input logic [15:0] eIrq, input logic eProc, input logic [7:0] eStat);
    wr(32'h0c, {24'h0, ctl});
    wr(32'h14, {24'h0, cfg});
    pins[p] <= v;
    repeat (6) @(posedge clk);
    chk("hostIrq", {16'h0, eIrq}, {16'h0, hostIrq});
    chk("procIrq", {31'h0, eProc}, {31'h0, procIrq});
    rd(32'h10, {24'h0, eStat}, "status");
    repeat (2) @(posedge clk);
    chk("irqCleared", 32'h0, {15'h0, procIrq, hostIrq});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_regs;
    rd(32'h14, 32'h0, "cfgReset");
    rd(32'h18, 32'h0, "mapReset");
    rd(32'h10, 32'h0, "statusReset");
    rd(32'h4c, 32'h1f, "pinLevels");
    wr(32'h14, 32'h5a);
    rd(32'h14, 32'h5a, "cfgRw");
    rd(32'h7c, 32'h0, "unmapped");
    $display("t_reset_regs done");
  endtask
  task automatic t_windows;
    logic [7:0] m;
    memHit <= 5'h1f;
    ioHit <= 2'h3;
    for (int i = 0; i < 8; i++) begin
      wr(32'h18, 32'h1 << i);
      repeat (2) @(posedge clk);
      m = 8'h1 << i;
      chk("respond", {24'h0, m[7:6], 1'b0, m[4:0]}, {24'h0, ioResp, 1'b0, memResp});
    end
    wr(32'h18, 32'hff);
    memHit <= 5'h0;
    ioHit <= 2'h0;
    repeat (2) @(posedge clk);
    chk("noHit", 32'h0, {25'h0, ioResp, memResp});
    $display("t_windows done");
  endtask
  task automatic t_routing;
    logic [15:0] e;
    for (int c = 0; c < 16; c++) begin
      e = (c inside {0, 1, 2, 6, 8, 13}) ? 16'h0 : (16'h1 << c);
      evt(8'h00, {c[3:0], 4'h8}, 3, ~pins[3], e, 1'b0, 8'h08);
      chk("altSel", {28'h0, c == 15, c == 12, c == 10, c == 9}, {28'h0, altSel});
    end
    $display("t_routing done");
  endtask
  task automatic t_sources;
    evt(8'h00, 8'h30, 3, ~pins[3], 16'h0, 1'b0, 8'h08);
    evt(8'h00, 8'h31, 0, 1'b0, 16'h8, 1'b0, 8'h01);
    evt(8'h00, 8'h31, 0, 1'b1, 16'h0, 1'b0, 8'h00);
    evt(8'h20, 8'h31, 0, 1'b0, 16'h8, 1'b0, 8'h01);
    evt(8'h20, 8'h31, 0, 1'b1, 16'h8, 1'b0, 8'h01);
    evt(8'h00, 8'h32, 1, 1'b0, 16'h8, 1'b0, 8'h02);
    evt(8'h00, 8'h32, 1, 1'b1, 16'h0, 1'b0, 8'h00);
    evt(8'h20, 8'h32, 1, 1'b0, 16'h0, 1'b0, 8'h00);
    evt(8'h00, 8'h34, 2, 1'b0, 16'h8, 1'b0, 8'h04);
    evt(8'h00, 8'h30, 2, 1'b1, 16'h0, 1'b0, 8'h04);
    evt(8'h10, 8'h38, 3, ~pins[3], 16'h0, 1'b1, 8'h08);
    $display("t_sources done");
  endtask
  task automatic t_event_irq;
    wr(32'h44, 32'hf);
    wr(32'h48, 32'hf);
    pins[4] <= ~pins[4];
    repeat (6) @(posedge clk);
    chk("eventIrq", 32'h1, {31'h0, evtIrq});
    rd(32'h40, 32'h8, "evtStat");
    wr(32'h44, 32'h8);
    wr(32'h48, 32'h0);
    pins[4] <= ~pins[4];
    repeat (6) @(posedge clk);
    chk("masked", 32'h0, {31'h0, evtIrq});
    rd(32'h40, 32'h8, "evtStat");
    $display("t_event_irq done");
  endtask
  task automatic t_mid_reset;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(32'h14, 32'h0, "cfgMidReset");
    rd(32'h10, 32'h0, "statusMidReset");
    chk("irqMidReset", 32'h0, {15'h0, procIrq, hostIrq});
    $display("t_mid_reset done");
  endtask
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    pins = 5'h1f;
    memHit = 5'h0;
    ioHit = 2'h0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    t_reset_regs;
    t_windows;
    t_routing;
    t_sources;
    t_event_irq;
    t_mid_reset;
    print_verdict;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    print_verdict;
  end
endmodule
`default_nettype wire
